// ==== dsm_defines.svh ====
`ifndef DSM_DEFINES_SVH
`define DSM_DEFINES_SVH

// Register select codes, low three select lines with select line 3 high
`define DSM_SEL_STATUS_CMD 3'h0
`define DSM_SEL_REQUEST 3'h1
`define DSM_SEL_SINGLE_MASK 3'h2
`define DSM_SEL_MODE 3'h3
`define DSM_SEL_CLEAR_FF 3'h4
`define DSM_SEL_TEMP_MCLR 3'h5
`define DSM_SEL_ALL_MASK 3'h7

// Field positions
`define DSM_STAT_TC_LSB 0
`define DSM_STAT_REQ_LSB 4
`define DSM_BIT_CHAN_LSB 0
`define DSM_BIT_SET_POS 2
`define DSM_MODE_AUTOINIT_POS 4

// Reset values
`define DSM_MASK_RESET 4'hF
`define DSM_TEMP_RESET 8'h00
`define DSM_CMD_RESET 8'h00
`define DSM_MODE_RESET 6'h00

`endif

// ==== dsm_pkg.sv ====
package dsm_pkg;
  typedef logic [3:0] dsm_chan_t;
  typedef logic [7:0] dsm_byte_t;
  typedef enum logic [1:0] {
    DSM_IDLE,
    DSM_ACTIVE
  } dsm_cycle_t;
endpackage

// ==== dsm_status_if.sv ====
`timescale 1ns/10ps
interface dsm_status_if;
  logic [3:0] tc_event;
  logic [3:0] req_level;
  logic status_read;
  logic clear_all;
  logic [7:0] status_byte;
  modport ctrl (output tc_event, output req_level, output status_read, output clear_all,
    input status_byte);
  modport stat (input tc_event, input req_level, input status_read, input clear_all,
    output status_byte);
endinterface

// ==== dsm_status.sv ====
`timescale 1ns/10ps
`include "dsm_defines.svh"
module dsm_status
  import dsm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Status link
  dsm_status_if.stat st
);
  dsm_chan_t tc_flags;
  dsm_chan_t next_tc_flags;

  always_comb begin
    next_tc_flags = tc_flags;
    if (st.status_read || st.clear_all) begin
      next_tc_flags = 4'h0;
    end
    next_tc_flags = next_tc_flags | st.tc_event;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tc_flags <= 4'h0;
    end else begin
      tc_flags <= next_tc_flags;
    end
  end

  // live request bits
  // Formed in the read cycle itself, so the caller registers it with no stale byte
  assign st.status_byte = {st.req_level, tc_flags | st.tc_event};
endmodule

// ==== dsm_ctrl.sv ====
`timescale 1ns/10ps
`include "dsm_defines.svh"
// How it works
// - Terminal-count status bits 0-3 set on each channel terminal count.
// - Terminal-count bits clear on reset and on every status read, except a terminal count arriving in the read cycle, which stays set.
// - Status bits 4-7 show channels currently requesting service.
// - Temporary register keeps last memory-to-memory byte until reset.
// - Clear-flip-flop and master clear ignore the data bus value.
// - Clear-flip-flop command makes next byte access take the low byte.
// - Master clear acts as reset: clears registers, sets mask, idles.
// - Select line 3 high; low three lines decode the register function.
// - Set mask bit blocks that channel's hardware request.
// - End of process without autoinit sets that channel's mask bit.
// - Single-mask write sets or clears one chosen mask bit only.
// - Reset sets all mask bits, blocking every hardware request.
// - Write-all-mask loads four mask bits from one byte.
// - Software request bit clears on terminal count or end of process.
module dsm_ctrl
  import dsm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host register port
  input wire logic register_select_0,
  input wire logic register_select_1,
  input wire logic register_select_2,
  input wire logic register_select_3,
  input wire logic io_read_strobe,
  input wire logic io_write_strobe,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_out_valid,
  // Channel side
  input wire logic [3:0] channel_request_input,
  input wire logic [3:0] terminal_count,
  input wire logic [3:0] end_of_process,
  input wire logic addr_count_access,
  input wire logic mem_xfer_strobe,
  input wire logic [7:0] mem_xfer_byte,
  // Block state
  output logic [3:0] channel_request_block,
  output logic [3:0] recognized_request,
  output logic [3:0] software_request,
  output logic [7:0] command_reg,
  output logic byte_high_select,
  output logic controller_idle
);
  // ==========================================================
  // Input synchronisers
  logic [3:0] channel_request_input_meta;
  logic [3:0] channel_request_input_sync;
  logic [3:0] tc_meta;
  logic [3:0] tc_sync;
  logic [3:0] eop_meta;
  logic [3:0] eop_sync;
  logic [3:0] tc_prev;
  logic [3:0] eop_prev;
  logic [3:0] tc_rise;
  logic [3:0] eop_rise;

  always_ff @(posedge clk) begin
    if (srst) begin
      channel_request_input_meta <= 4'h0;
      channel_request_input_sync <= 4'h0;
      tc_meta <= 4'h0;
      tc_sync <= 4'h0;
      eop_meta <= 4'h0;
      eop_sync <= 4'h0;
      tc_prev <= 4'h0;
      eop_prev <= 4'h0;
    end else begin
      channel_request_input_meta <= channel_request_input;
      channel_request_input_sync <= channel_request_input_meta;
      tc_meta <= terminal_count;
      tc_sync <= tc_meta;
      eop_meta <= end_of_process;
      eop_sync <= eop_meta;
      tc_prev <= tc_sync;
      eop_prev <= eop_sync;
    end
  end

  assign tc_rise = tc_sync & ~tc_prev;
  assign eop_rise = eop_sync & ~eop_prev;

  // ==========================================================
  // Access decode
  logic [2:0] sel;
  logic rd_prev;
  logic wr_prev;
  logic rd_pulse;
  logic wr_pulse;

  function automatic logic [3:0] dsm_onehot(input logic [1:0] ch);
    dsm_onehot = 4'h1 << ch;
  endfunction

  assign sel = {register_select_2, register_select_1, register_select_0};

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      rd_prev <= io_read_strobe;
      wr_prev <= io_write_strobe;
    end
  end

  // one strobe per access, edge taken once
  assign rd_pulse = io_read_strobe & ~rd_prev & ~io_write_strobe & register_select_3;
  assign wr_pulse = io_write_strobe & ~wr_prev & ~io_read_strobe & register_select_3;

  logic status_rd;
  logic temp_rd;
  logic cmd_wr;
  logic req_wr;
  logic smask_wr;
  logic mode_wr;
  logic clrff_wr;
  logic mclr_wr;
  logic amask_wr;

  always_comb begin
    status_rd = 1'b0;
    temp_rd = 1'b0;
    cmd_wr = 1'b0;
    req_wr = 1'b0;
    smask_wr = 1'b0;
    mode_wr = 1'b0;
    clrff_wr = 1'b0;
    mclr_wr = 1'b0;
    amask_wr = 1'b0;
    if (rd_pulse && sel == `DSM_SEL_STATUS_CMD) begin
      status_rd = 1'b1;
    end else if (rd_pulse && sel == `DSM_SEL_TEMP_MCLR) begin
      temp_rd = 1'b1;
    end else if (wr_pulse && sel == `DSM_SEL_STATUS_CMD) begin
      cmd_wr = 1'b1;
    end else if (wr_pulse && sel == `DSM_SEL_REQUEST) begin
      req_wr = 1'b1;
    end else if (wr_pulse && sel == `DSM_SEL_SINGLE_MASK) begin
      smask_wr = 1'b1;
    end else if (wr_pulse && sel == `DSM_SEL_MODE) begin
      mode_wr = 1'b1;
    end else if (wr_pulse && sel == `DSM_SEL_CLEAR_FF) begin
      clrff_wr = 1'b1;
    end else if (wr_pulse && sel == `DSM_SEL_TEMP_MCLR) begin
      mclr_wr = 1'b1;
    end else if (wr_pulse && sel == `DSM_SEL_ALL_MASK) begin
      amask_wr = 1'b1;
    end
  end

  // ==========================================================
  // Status register
  dsm_status_if st_link ();
  assign st_link.tc_event = tc_rise;
  assign st_link.req_level = channel_request_input_sync | software_request;
  assign st_link.status_read = status_rd;
  assign st_link.clear_all = mclr_wr;

  dsm_status u_status (
    .clk(clk),
    .srst(srst),
    .st(st_link)
  );

  // ==========================================================
  // Control state
  dsm_chan_t next_mask;
  dsm_chan_t next_sreq;
  dsm_byte_t next_cmd;
  dsm_byte_t temp_reg;
  dsm_byte_t next_temp;
  logic [5:0] mode_reg [4];
  logic [5:0] next_mode [4];
  logic next_byte_ff;
  dsm_cycle_t cycle;
  dsm_cycle_t next_cycle;
  logic [3:0] autoinit;
  logic [7:0] next_dout;
  logic next_dvalid;
  logic [3:0] next_recog;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      autoinit[i] = mode_reg[i][`DSM_MODE_AUTOINIT_POS];
    end
  end

  always_comb begin
    next_mask = channel_request_block;
    next_sreq = software_request;
    next_cmd = command_reg;
    next_temp = temp_reg;
    next_mode = mode_reg;
    next_byte_ff = byte_high_select;
    next_cycle = cycle;
    next_dout = data_out;
    next_dvalid = 1'b0;
    if (mem_xfer_strobe) begin
      next_temp = mem_xfer_byte;
    end
    if (addr_count_access) begin
      next_byte_ff = ~byte_high_select;
    end
    if (clrff_wr) begin
      next_byte_ff = 1'b0;
    end
    if (cmd_wr) begin
      next_cmd = data_in;
    end
    if (mode_wr) begin
      next_mode[data_in[1:0]] = data_in[7:2];
    end
    if (req_wr) begin
      next_sreq[data_in[1:0]] = data_in[`DSM_BIT_SET_POS];
    end
    next_sreq = next_sreq & ~(tc_rise | eop_rise);
    if (smask_wr) begin
      next_mask[data_in[1:0]] = data_in[`DSM_BIT_SET_POS];
    end
    if (amask_wr) begin
      next_mask = data_in[3:0];
    end
    next_mask = next_mask | (eop_rise & ~autoinit);
    if (|(channel_request_input_sync & ~next_mask) || |software_request) begin
      next_cycle = DSM_ACTIVE;
    end else begin
      next_cycle = DSM_IDLE;
    end
    if (status_rd) begin
      next_dout = st_link.status_byte;
      next_dvalid = 1'b1;
    end
    if (temp_rd) begin
      next_dout = temp_reg;
      next_dvalid = 1'b1;
    end
    if (mclr_wr) begin
      next_mask = `DSM_MASK_RESET;
      next_sreq = 4'h0;
      next_cmd = `DSM_CMD_RESET;
      next_temp = `DSM_TEMP_RESET;
      next_byte_ff = 1'b0;
      next_cycle = DSM_IDLE;
      for (int i = 0; i < 4; i++) begin
        next_mode[i] = `DSM_MODE_RESET;
      end
    end
  end

  assign next_recog = mclr_wr ? 4'h0 : (channel_request_input_sync & ~channel_request_block);

  always_ff @(posedge clk) begin
    if (srst) begin
      channel_request_block <= `DSM_MASK_RESET;
      software_request <= 4'h0;
      command_reg <= `DSM_CMD_RESET;
      temp_reg <= `DSM_TEMP_RESET;
      byte_high_select <= 1'b0;
      cycle <= DSM_IDLE;
      data_out <= 8'h00;
      data_out_valid <= 1'b0;
      recognized_request <= 4'h0;
      controller_idle <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        mode_reg[i] <= `DSM_MODE_RESET;
      end
    end else begin
      channel_request_block <= next_mask;
      software_request <= next_sreq;
      command_reg <= next_cmd;
      temp_reg <= next_temp;
      byte_high_select <= next_byte_ff;
      cycle <= next_cycle;
      data_out <= next_dout;
      data_out_valid <= next_dvalid;
      recognized_request <= next_recog;
      controller_idle <= (next_cycle == DSM_IDLE);
      mode_reg <= next_mode;
    end
  end
endmodule

// ==== dsm_ctrl_chk.sv ====
`timescale 1ns/10ps
module dsm_ctrl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host port
  input wire logic register_select_0,
  input wire logic register_select_1,
  input wire logic register_select_2,
  input wire logic register_select_3,
  input wire logic io_read_strobe,
  input wire logic io_write_strobe,
  input wire logic [7:0] data_in,
  input wire logic data_out_valid,
  input wire logic addr_count_access,
  // Block state
  input wire logic [3:0] channel_request_block,
  input wire logic [3:0] recognized_request,
  input wire logic [3:0] software_request,
  input wire logic [7:0] command_reg,
  input wire logic byte_high_select
);
  logic pw;
  logic pr;
  logic wt;
  logic rt;
  logic [2:0] sel;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk) begin
    pw <= io_write_strobe;
    pr <= io_read_strobe;
  end
  // ==========
  // Access taken only on a fresh strobe
  assign sel = {register_select_2, register_select_1, register_select_0};
  assign wt = io_write_strobe && !pw && !io_read_strobe && register_select_3;
  assign rt = io_read_strobe && !pr && !io_write_strobe && register_select_3;
  property p_reset_mask;
    $fell(srst) |-> channel_request_block == 4'hF && software_request == 4'h0;
  endproperty
  a_reset_mask: assert property (p_reset_mask) else $error("mask not set");
  property p_all_mask;
    wt && sel == 3'h7 |=> channel_request_block == $past(data_in[3:0]);
  endproperty
  a_all_mask: assert property (p_all_mask) else $error("all mask bad");
  property p_one_mask;
    wt && sel == 3'h2 |=> channel_request_block[$past(data_in[1:0])] == $past(data_in[2]);
  endproperty
  a_one_mask: assert property (p_one_mask) else $error("single mask bad");
  property p_read_ok;
    rt && (sel == 3'h0 || sel == 3'h5) |=> data_out_valid;
  endproperty
  a_read_ok: assert property (p_read_ok) else $error("read not answered");
  property p_read_bad;
    rt && sel != 3'h0 && sel != 3'h5 |=> !data_out_valid;
  endproperty
  a_read_bad: assert property (p_read_bad) else $error("illegal read answered");
  // Mask held over two edges, so a bit set in both mask stages must block
  property p_mask_gate;
    (recognized_request & channel_request_block & $past(channel_request_block)) == 4'h0;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked request seen");
  property p_clear_ff;
    wt && sel == 3'h4 |=> !byte_high_select;
  endproperty
  a_clear_ff: assert property (p_clear_ff) else $error("byte flop not cleared");
  property p_master_clear;
    wt && sel == 3'h5 |=> channel_request_block == 4'hF && command_reg == 8'h00
      && software_request == 4'h0 && !byte_high_select;
  endproperty
  a_master_clear: assert property (p_master_clear) else $error("master clear bad");
  property p_byte_toggle;
    addr_count_access && !wt |=> byte_high_select != $past(byte_high_select);
  endproperty
  a_byte_toggle: assert property (p_byte_toggle) else $error("byte flop stuck");
endmodule
bind dsm_ctrl dsm_ctrl_chk i_chk (.clk, .srst, .register_select_0, .register_select_1,
  .register_select_2, .register_select_3, .io_read_strobe, .io_write_strobe, .data_in,
  .data_out_valid, .addr_count_access, .channel_request_block, .recognized_request,
  .software_request, .command_reg, .byte_high_select);

// ==== dsm_host.sv ====
`timescale 1ns/10ps
module dsm_host
  import dsm_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic [3:0] sel,
  output logic io_read_strobe,
  output logic io_write_strobe,
  output dsm_byte_t data_in,
  input wire logic [7:0] data_out,
  input wire logic data_out_valid
);
  initial begin
    sel = 4'h0;
    io_read_strobe = 1'b0;
    io_write_strobe = 1'b0;
    data_in = 8'h00;
  end
  // ==========
  // one strobe, stable selects
  task automatic acc(input logic rd, input logic [3:0] a, input dsm_byte_t d,
      output dsm_byte_t q, output logic v);
    @(negedge clk);
    sel = a;
    data_in = d;
    io_read_strobe = rd;
    io_write_strobe = !rd;
    @(negedge clk);
    // Answer stands only one cycle after the taking edge
    q = data_out;
    v = data_out_valid;
    io_read_strobe = 1'b0;
    io_write_strobe = 1'b0;
    // Released bus shows junk, never the old byte
    data_in = ~d;
    // Idle cycle keeps the two-cycle access spacing
    @(negedge clk);
  endtask
endmodule

// ==== dsm_status_mask_command_port_tb_top.sv ====
`timescale 1ns/10ps
module dsm_status_mask_command_port_tb_top;
  import dsm_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] sel;
  logic io_read_strobe, io_write_strobe, data_out_valid, addr_count_access, mem_xfer_strobe;
  logic byte_high_select, controller_idle, v;
  dsm_byte_t data_in, data_out, mem_xfer_byte, command_reg, q;
  dsm_chan_t channel_request_input, terminal_count, end_of_process;
  dsm_chan_t channel_request_block, recognized_request, software_request;
  int failures, checks_done;
  initial forever #5 clk = ~clk;
  dsm_host i_host (.clk, .sel, .io_read_strobe, .io_write_strobe, .data_in, .data_out,
    .data_out_valid);
  dsm_ctrl i_dut (.clk, .srst, .register_select_0(sel[0]), .register_select_1(sel[1]),
    .register_select_2(sel[2]), .register_select_3(sel[3]), .io_read_strobe,
    .io_write_strobe, .data_in, .data_out, .data_out_valid, .channel_request_input,
    .terminal_count, .end_of_process, .addr_count_access, .mem_xfer_strobe, .mem_xfer_byte,
    .channel_request_block, .recognized_request, .software_request, .command_reg,
    .byte_high_select, .controller_idle);
  task chk(input dsm_byte_t s, input dsm_byte_t e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input logic [3:0] a, input dsm_byte_t d);
    i_host.acc(1'b0, a, d, q, v);
  endtask
  task rd(input logic [3:0] a);
    i_host.acc(1'b1, a, 8'h00, q, v);
  endtask
  function automatic dsm_byte_t mk();
    return {4'h0, channel_request_block};
  endfunction
  // ==========
  // Watchdog
  initial begin
    cyc(5000);
    failures++;
    give_verdict;
  end
  initial begin
    {channel_request_input, terminal_count, end_of_process} = 12'h000;
    {addr_count_access, mem_xfer_strobe, mem_xfer_byte} = 10'h000;
    cyc(6);
    srst = 1'b0;
    chk({controller_idle, 3'h0, channel_request_block}, 8'h8F);
    rd(4'hD); chk(q, 8'h00);
    chk({7'h0, v}, 8'h01);
    wr(4'hF, 8'hF5); chk(mk(), 8'h05);
    wr(4'hA, 8'h05); chk(mk(), 8'h07);
    wr(4'hA, 8'hF8); chk(mk(), 8'h06);
    channel_request_input = 4'h3;
    cyc(5);
    chk({4'h0, recognized_request}, 8'h01);
    rd(4'h8); chk(q, 8'h30);
    channel_request_input = 4'h0;
    terminal_count = 4'h4;
    cyc(2);
    terminal_count = 4'h0;
    cyc(4);
    rd(4'h8); chk(q, 8'h04);
    rd(4'h8); chk(q, 8'h00);
    mem_xfer_byte = 8'hA5;
    mem_xfer_strobe = 1'b1;
    cyc(1);
    mem_xfer_strobe = 1'b0;
    rd(4'hD); chk(q, 8'hA5);
    // Illegal read codes give no answer
    for (int i = 1; i < 8; i++) if (i != 5) begin
      rd(4'h8 | 4'(i)); chk({7'h0, v}, 8'h00);
    end
    wr(4'hE, 8'h00); chk(mk(), 8'h06);
    wr(4'h7, 8'h00); chk(mk(), 8'h06);
    wr(4'h8, 8'h3C); chk(command_reg, 8'h3C);
    addr_count_access = 1'b1;
    cyc(1);
    addr_count_access = 1'b0;
    cyc(1);
    chk({7'h0, byte_high_select}, 8'h01);
    wr(4'hC, 8'hFF); chk({7'h0, byte_high_select}, 8'h00);
    wr(4'hB, 8'h00);
    wr(4'h9, 8'h04); chk({4'h0, software_request}, 8'h01);
    end_of_process = 4'h1;
    cyc(2);
    end_of_process = 4'h0;
    cyc(4);
    chk({software_request, channel_request_block}, 8'h07);
    // Autoinit channel keeps its mask bit clear at end of process
    wr(4'hB, 8'h43);
    end_of_process = 4'h8;
    cyc(2);
    end_of_process = 4'h0;
    cyc(4);
    chk({software_request, channel_request_block}, 8'h07);
    wr(4'h9, 8'h07);
    addr_count_access = 1'b1;
    cyc(1);
    addr_count_access = 1'b0;
    wr(4'hD, 8'h5A);
    chk({software_request, channel_request_block}, 8'h0F);
    chk(command_reg, 8'h00);
    chk({controller_idle, 6'h0, byte_high_select}, 8'h80);
    rd(4'hD); chk(q, 8'h00);
    give_verdict;
  end
endmodule
